/* common/checksum_defines.svh */
`ifndef CHECKSUM_DEFINES_SVH
`define CHECKSUM_DEFINES_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DATA_W 8'h04
`define OFS_DATA_B 8'h08
`define OFS_RESULT 8'h0C
`define OFS_STATUS 8'h10
// control fields
`define CTRL_POLY_LSB 0
`define CTRL_INREV 2
`define CTRL_SWAP 3
`define CTRL_OUTREV_LSB 4
`define CTRL_SEED1 6
`define CTRL_FREEZE 7
`define CTRL_DMAREQ 8
`define CTRL_WIDTH 8
// status fields
`define STAT_LEVEL_LSB 0
`define STAT_EMPTY 8
`define STAT_FULL 9
`define STAT_OVF 10
// generator polynomials, implicit top bit left out
`define POLY32 32'h04C1_1DB7
`define POLY16_A 32'h0000_1021
`define POLY16_B 32'h0000_3D65
`define POLY16_C 32'h0000_8005
// reset and seed values
`define CTRL_RESET 8'h00
`define CRC_RESET 32'h0000_0000
`define SEED16_ONES 32'h0000_FFFF
`define SEED32_ONES 32'hFFFF_FFFF
`endif

/* common/checksum_pkg.sv */
`include "checksum_defines.svh"
package checksum_pkg;
	typedef enum logic [1:0] {POLY_32 = 2'h0, POLY_1021 = 2'h1, POLY_3D65 = 2'h2, POLY_8005 = 2'h3} polySel_t;
	typedef enum logic [1:0] {OUT_PLAIN = 2'h0, OUT_WORD = 2'h1, OUT_HALF = 2'h2, OUT_HALF2 = 2'h3} outRev_t;
	typedef enum logic [1:0] {ENG_RUN = 2'b01, ENG_HOLD = 2'b10} engState_t;
	function automatic logic [31:0] revInBytes(input logic [31:0] d);
		logic [31:0] r;
		for (int i = 0; i < 32; i++) r[i] = d[(i & ~7) + 7 - (i & 7)];
		return r;
	endfunction
	function automatic logic [31:0] swapBytes(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction
	function automatic logic [31:0] rev32(input logic [31:0] d);
		logic [31:0] r;
		for (int i = 0; i < 32; i++) r[i] = d[31 - i];
		return r;
	endfunction
	function automatic logic [31:0] outXform(input logic [31:0] c, input outRev_t m);
		logic [31:0] r;
		r = rev32(c);
		case (m)
			OUT_WORD: return r;
			OUT_HALF, OUT_HALF2: return {r[15:0], r[31:16]};
			default: return c;
		endcase
	endfunction
	function automatic logic [31:0] polyValue(input polySel_t p);
		case (p)
			POLY_1021: return `POLY16_A;
			POLY_3D65: return `POLY16_B;
			POLY_8005: return `POLY16_C;
			default: return `POLY32;
		endcase
	endfunction
	// msb-first fold of 8 or 32 data bits, fully unrolled
	function automatic logic [31:0] crcFold(input logic [31:0] c, input logic [31:0] d, input logic isByte,
		input polySel_t p);
		logic [31:0] r;
		logic [31:0] g;
		logic fb;
		r = c;
		g = polyValue(p);
		for (int i = 31; i >= 0; i--) begin
			if (!isByte || i < 8) begin
				if (p == POLY_32) begin
					fb = r[31] ^ d[i];
					r = {r[30:0], 1'b0} ^ (fb ? g : 32'h0000_0000);
				end else begin
					fb = r[15] ^ d[i];
					r = {16'h0000, r[14:0], 1'b0} ^ (fb ? g : 32'h0000_0000);
				end
			end
		end
		return r;
	endfunction
endpackage

/* common/stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
// one word stream: data held while valid, taken when ready
interface stream_if #(parameter int W = 33) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

/* verilog/crc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module crc_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	stream_if.snk fill,
	stream_if.src drain,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic push;
	logic pop;

	// pointers carry one extra bit so full and empty differ
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("crc_fifo: DEPTH must be a power of two, at least 2");
	end

	assign level = wrPtr_q - rdPtr_q;
	assign fill.ready = level != (AW + 1)'(DEPTH);
	assign drain.valid = level != '0;
	assign drain.data = mem[rdPtr_q[AW-1:0]];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	// storage, no reset needed on the data words
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= fill.data;
		end
	end

	// flush drops everything queued, including a same-cycle push
	always_ff @(posedge clk) begin
		if (!rst_n || flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) wrPtr_q <= wrPtr_q + (AW + 1)'(1);
			if (pop) rdPtr_q <= rdPtr_q + (AW + 1)'(1);
		end
	end
endmodule // crc_fifo
`default_nettype wire

/* verilog/crc_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "checksum_defines.svh"
module crc_engine (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic seedLoad,
	input wire logic [31:0] seedVal,
	input wire logic hold,
	input wire checksum_pkg::polySel_t poly,
	stream_if.snk feed,
	output logic [31:0] crc,
	output logic [31:0] crcNow,
	output checksum_pkg::engState_t state
);
	import checksum_pkg::*;
	logic [31:0] crc_q;
	logic [31:0] crcNext;
	engState_t state_q;
	logic fire;

	// one block of 8 or 32 bits per clock, no stall of its own
	assign feed.ready = (state_q == ENG_RUN) && !seedLoad;
	assign fire = feed.valid && feed.ready;
	assign crcNext = crcFold(crc_q, feed.data[31:0], feed.data[32], poly);
	assign crcNow = fire ? crcNext : crc_q;
	assign crc = crc_q;
	assign state = state_q;

	// hold lets the queue fill behind a paused engine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ENG_RUN;
		end else begin
			case (state_q)
				ENG_RUN: if (hold) state_q <= ENG_HOLD;
				ENG_HOLD: if (!hold) state_q <= ENG_RUN;
				default: state_q <= ENG_RUN;
			endcase
		end
	end

	// a seed always wins over a block in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			crc_q <= `CRC_RESET;
		end else if (seedLoad) begin
			crc_q <= seedVal;
		end else if (fire) begin
			crc_q <= crcNext;
		end
	end
endmodule // crc_engine
`default_nettype wire

/* verilog/checksum_unit.sv */
// Behaviour
// - a 32-bit mode uses generator 0x04C11DB7.
// - three 16-bit modes use 0x1021, 0x3D65 and 0x8005.
// - optional bit reversal inside every input byte.
// - optional byte reordering of every input word.
// - result may read bit-reversed over the word or per half-word.
// - one control write sets polynomial, options and seed together.
// - a 32-bit or 8-bit block folds in one clock.
// - back-to-back word writes absorbed at 32 bits per clock.
// - input may come from DMA started by a firmware request.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "checksum_defines.svh"
module checksum_unit #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [31:0] rdata,
	output logic dataReady,
	output logic dmaSwReq
);
	import checksum_pkg::*;
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	// the status word has room for a level of at most eight bits
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_chk
		$error("checksum_unit: FIFO_DEPTH out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [`CTRL_WIDTH-1:0] ctrl_q;
	logic ovf_q;
	logic dmaReq_q;
	logic [31:0] rdata_q;
	logic ctrlWr;
	logic dataWr;
	logic byteWr;
	logic statWr;
	logic [31:0] inWord;
	logic [31:0] seedVal;
	logic [31:0] crcVal;
	logic [31:0] crcNow;
	logic [LW-1:0] level;
	polySel_t cfgPoly;
	outRev_t cfgOut;
	engState_t engState;
	stream_if #(.W(33)) fillS ();
	stream_if #(.W(33)) drainS ();

	////////////////////////////////////////////////////////////////////////////
	// address decode

	// unmapped writes fall through and change nothing
	assign ctrlWr = wrEn && addr == `OFS_CTRL;
	assign dataWr = wrEn && (addr == `OFS_DATA_W || addr == `OFS_DATA_B);
	assign byteWr = addr == `OFS_DATA_B;
	assign statWr = wrEn && addr == `OFS_STATUS;

	////////////////////////////////////////////////////////////////////////////
	// configuration

	assign cfgPoly = polySel_t'(ctrl_q[`CTRL_POLY_LSB +: 2]);
	assign cfgOut = outRev_t'(ctrl_q[`CTRL_OUTREV_LSB +: 2]);

	// config and seed land in the same write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `CTRL_RESET;
		end else if (ctrlWr) begin
			ctrl_q <= wdata[`CTRL_WIDTH-1:0];
		end
	end

	// seed width follows the newly written polynomial, not the old one
	always_comb begin
		seedVal = `CRC_RESET;
		if (wdata[`CTRL_SEED1]) begin
			seedVal = (wdata[`CTRL_POLY_LSB +: 2] == POLY_32) ? `SEED32_ONES : `SEED16_ONES;
		end
	end

	// firmware-kicked dma request, one clock wide
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dmaReq_q <= 1'b0;
		end else begin
			dmaReq_q <= ctrlWr && wdata[`CTRL_DMAREQ];
		end
	end
	assign dmaSwReq = dmaReq_q;

	////////////////////////////////////////////////////////////////////////////
	// input shaping

	// transforms applied on the way in, so queued words are final
	always_comb begin
		inWord = wdata;
		if (ctrl_q[`CTRL_SWAP] && !byteWr) begin
			inWord = swapBytes(inWord);
		end
		if (ctrl_q[`CTRL_INREV]) begin
			inWord = revInBytes(inWord);
		end
		if (byteWr) begin
			inWord = {24'h00_0000, inWord[7:0]};
		end
	end

	// dma and cpu share the same write port
	assign fillS.valid = dataWr;
	assign fillS.data = {byteWr, inWord};
	assign dataReady = fillS.ready;

	////////////////////////////////////////////////////////////////////////////
	// queue and engine

	// a control write flushes stale words so they never touch a new seed
	crc_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(ctrlWr),
		.fill(fillS),
		.drain(drainS),
		.level(level)
	);

	crc_engine u_engine (
		.clk(clk),
		.rst_n(rst_n),
		.seedLoad(ctrlWr),
		.seedVal(seedVal),
		.hold(ctrl_q[`CTRL_FREEZE]),
		.poly(cfgPoly),
		.feed(drainS),
		.crc(crcVal),
		.crcNow(crcNow),
		.state(engState)
	);

	////////////////////////////////////////////////////////////////////////////
	// status

	// a write dropped on a full queue is flagged; a new drop beats the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
		end else if (dataWr && !fillS.ready) begin
			ovf_q <= 1'b1;
		end else if (statWr && wdata[`STAT_OVF]) begin
			ovf_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path

	// crcNow includes a block folding this very cycle, so a read misses only words still waiting in the queue
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (rdEn) begin
			case (addr)
				`OFS_CTRL: rdata_q <= {{(32 - `CTRL_WIDTH){1'b0}}, ctrl_q};
				`OFS_RESULT: rdata_q <= outXform(crcNow, cfgOut);
				`OFS_STATUS: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[`STAT_LEVEL_LSB +: LW] <= level;
					rdata_q[`STAT_EMPTY] <= level == '0;
					rdata_q[`STAT_FULL] <= !fillS.ready;
					rdata_q[`STAT_OVF] <= ovf_q;
				end
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence seqWordWrite;
		wrEn && addr == `OFS_DATA_W && fillS.ready && level == '0 && engState == ENG_RUN
			&& !ctrl_q[`CTRL_FREEZE];
	endsequence
	sequence seqResultRead;
		rdEn && addr == `OFS_RESULT;
	endsequence

	a_poly_wide: assert property (crcFold(32'h0, 32'h1, 1'b1, POLY_32) == `POLY32)
		else $error("32-bit generator wrong");
	a_poly_narrow: assert property (crcFold(32'h0, 32'h1, 1'b1, POLY_1021) == `POLY16_A
		&& crcFold(32'h0, 32'h1, 1'b1, POLY_3D65) == `POLY16_B
		&& crcFold(32'h0, 32'h1, 1'b1, POLY_8005) == `POLY16_C)
		else $error("16-bit generator wrong");
	a_in_bitrev: assert property (seqWordWrite and ctrl_q[`CTRL_INREV] && !ctrl_q[`CTRL_SWAP]
		|=> drainS.data[31:0] == revInBytes($past(wdata)))
		else $error("input bit reversal wrong");
	a_byte_swap: assert property (seqWordWrite and ctrl_q[`CTRL_SWAP] && !ctrl_q[`CTRL_INREV]
		|=> drainS.data[31:0] == swapBytes($past(wdata)))
		else $error("input byte order wrong");
	a_out_rev: assert property (seqResultRead and cfgOut == OUT_WORD && !(drainS.valid && drainS.ready)
		|=> rdata == rev32($past(crcVal)))
		else $error("result reversal wrong");
	a_seed_config: assert property (ctrlWr |=> ctrl_q == $past(wdata[`CTRL_WIDTH-1:0])
		&& crcVal == $past(seedVal) && level == '0)
		else $error("config write did not seed");
	a_fold_block: assert property (drainS.valid && drainS.ready && !ctrlWr |=> crcVal
		== crcFold($past(crcVal), $past(drainS.data[31:0]), $past(drainS.data[32]), $past(cfgPoly)))
		else $error("block fold wrong");
	a_word_rate: assert property (seqWordWrite ##1 (wrEn && addr == `OFS_DATA_W && !ctrlWr)
		|-> dataReady ##1 level == (LW)'(1))
		else $error("back-to-back words stalled");
	a_dma_kick: assert property (ctrlWr && wdata[`CTRL_DMAREQ] |=> dmaSwReq ##1 !dmaSwReq)
		else $error("dma request pulse wrong");
	a_read_fresh: assert property (seqWordWrite ##1 (seqResultRead and !ctrlWr)
		|=> rdata == outXform(crcVal, cfgOut))
		else $error("result read stale");
	a_byte_block: assert property (wrEn && addr == `OFS_DATA_B && fillS.ready && level == '0
		|=> drainS.data[32] && drainS.data[31:8] == 24'h00_0000)
		else $error("byte write not marked");
	a_overflow_flag: assert property (dataWr && !fillS.ready |=> ovf_q)
		else $error("drop not flagged");

	////////////////////////////////////////////////////////////////////////////
	// further guards on the read path, queue, engine, input shaping, overflow flag and request pulse

	// read data must fall back to zero when no read was issued
	a_rdata_idle: assert property (!rdEn |=> rdata == 32'h0000_0000)
		else $error("read data not idle");

	// a full queue must refuse further words, else data would be overwritten
	a_queue_full: assert property (level == (LW)'(FIFO_DEPTH) |-> !dataReady)
		else $error("full queue still ready");

	// a held engine takes nothing from the queue
	a_hold_stall: assert property (engState == ENG_HOLD |-> !drainS.ready)
		else $error("held engine consumed data");

	// control reads return the stored configuration
	a_ctrl_readback: assert property (rdEn && addr == `OFS_CTRL
		|=> rdata == {{(32 - `CTRL_WIDTH){1'b0}}, $past(ctrl_q)})
		else $error("control readback wrong");

	// the request pulse only follows a control write
	a_dma_quiet: assert property (!ctrlWr |=> !dmaSwReq)
		else $error("spurious dma request");

	// byte writes ignore the swap option so the low byte stays in place
	a_byte_noswap: assert property (wrEn && addr == `OFS_DATA_B && fillS.ready && level == '0
		&& ctrl_q[`CTRL_SWAP] && !ctrl_q[`CTRL_INREV]
		|=> drainS.data[7:0] == $past(wdata[7:0]))
		else $error("byte write was swapped");

	// without a block or a seed the result must not move
	a_crc_steady: assert property (!(drainS.valid && drainS.ready) && !ctrlWr
		|=> crcVal == $past(crcVal))
		else $error("result changed without input");

	// clearing the sticky flag works when no new drop competes
	a_ovf_clear: assert property (statWr && wdata[`STAT_OVF] |=> !ovf_q)
		else $error("overflow flag not cleared");
endmodule // checksum_unit
`default_nettype wire

/* verification/dma_feeder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "checksum_defines.svh"
// stands in for the dma controller: a block of word writes started by firmware
module dma_feeder #(
	parameter int NWORDS = 5,
	parameter logic [31:0] BASE = 32'hC0DE_0000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic ready,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wrEn,
	output logic busy
);
	int k;
	////////////////////////////////////////////////////////////////
	// starts only on the firmware pulse, never on a trigger of its own
	// issues a write only while the queue has room, since a refused write is lost
	always @(posedge clk) begin
		if (!rst_n) begin
			wrEn <= 1'b0;
			busy <= 1'b0;
			k <= 0;
			addr <= 8'h00;
			wdata <= 32'h0000_0000;
		end else if (!busy) begin
			wrEn <= 1'b0;
			busy <= req;
			k <= 0;
			wdata <= ~wdata;
		end else if (k == NWORDS) begin
			wrEn <= 1'b0;
			busy <= 1'b0;
			wdata <= ~wdata;
		end else if (ready) begin
			wrEn <= 1'b1;
			addr <= `OFS_DATA_W;
			wdata <= BASE + 32'(k);
			k <= k + 1;
		end else begin
			wrEn <= 1'b0;
			wdata <= ~wdata; // released data never keeps its last value
		end
	end
endmodule // dma_feeder
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "checksum_defines.svh"
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] tAddr = 8'h00;
	logic [31:0] tData = 32'h0000_0000;
	logic tWr = 1'b0;
	logic tRd = 1'b0;
	logic [7:0] fAddr;
	logic [31:0] fData;
	logic fWr, fBusy, dataReady, dmaSwReq;
	logic [31:0] rdata, crc, ctrl, wd;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	int reqCycles = 0;

	always #20 clk = ~clk;

	// the block writer owns the bus while it runs
	checksum_unit #(.FIFO_DEPTH(8)) checksum_unit_i (.clk(clk), .rst_n(rst_n), .addr(fBusy ? fAddr : tAddr),
		.wdata(fBusy ? fData : tData), .wrEn(fBusy ? fWr : tWr), .rdEn(tRd & !fBusy), .rdata(rdata),
		.dataReady(dataReady), .dmaSwReq(dmaSwReq));
	dma_feeder #(.NWORDS(5), .BASE(32'hC0DE_0000)) dma_feeder_i (.clk(clk), .rst_n(rst_n), .req(dmaSwReq),
		.ready(dataReady), .addr(fAddr), .wdata(fData), .wrEn(fWr), .busy(fBusy));

	////////////////////////////////////////////////////////////////
	// reference arithmetic, bit-serial on purpose so it shares only the generator defines with the design
	function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input int n,
		input logic [1:0] p);
		logic [31:0] g;
		int top;
		g = p == 2'h0 ? `POLY32 : p == 2'h1 ? `POLY16_A : p == 2'h2 ? `POLY16_B : `POLY16_C;
		top = p == 2'h0 ? 31 : 15;
		for (int i = n - 1; i >= 0; i--) begin
			c = (c << 1) ^ ((c[top] ^ d[i]) ? g : 32'h0000_0000);
			if (top == 15) c[31:16] = 16'h0000;
		end
		return c;
	endfunction
	// byte swap first, then bits reversed inside each byte
	function automatic logic [31:0] feed(input logic [31:0] c, input logic [31:0] d, input logic isByte,
		input logic [31:0] cf);
		if (cf[3] && !isByte) d = {<<8{d}};
		if (cf[2]) begin
			d = {<<{d}};
			d = {<<8{d}};
		end
		return fold(c, d, isByte ? 8 : 32, cf[1:0]);
	endfunction
	function automatic logic [31:0] outx(input logic [31:0] c, input logic [1:0] m);
		logic [31:0] r;
		logic [15:0] hi, lo;
		r = {<<{c}};
		hi = {<<{c[31:16]}};
		lo = {<<{c[15:0]}};
		return m == 2'h0 ? c : m == 2'h1 ? r : {hi, lo};
	endfunction

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one bus cycle; idle data shows the inverse of the last value
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		tWr <= w;
		tRd <= r;
		tAddr <= a;
		tData <= w ? d : ~tData;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		#1 chk(rdata, exp);
	endtask
	task automatic finish_test();
		$display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hang guard, far above the roughly 250 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (dmaSwReq) reqCycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(`OFS_RESULT, `CRC_RESET);
		rd(`OFS_STATUS, 32'h0000_0100);
		rd(`OFS_CTRL, 32'h0000_0000);
		chk({31'h0, dataReady}, 32'h1);
		// every polynomial, option and output form; data written back to back
		for (int i = 0; i < 16; i++) begin
			ctrl = {24'h0, 1'b0, i[0] ^ i[3], i[2:1], i[3], i[2], i[1:0]};
			crc = ctrl[6] ? (ctrl[1:0] == 2'h0 ? `SEED32_ONES : `SEED16_ONES) : `CRC_RESET;
			bus(1'b1, 1'b0, `OFS_CTRL, ctrl);
			rd(`OFS_RESULT, outx(crc, ctrl[5:4]));
			for (int k = 0; k < 3; k++) begin
				wd = (32'h1234_5678 ^ (32'(i) * 32'h0913_0A07)) + 32'(k);
				bus(1'b1, 1'b0, `OFS_DATA_W, wd);
				crc = feed(crc, wd, 1'b0, ctrl);
			end
			wd = 32'hFFFF_FF00 | 32'(8'hA5 ^ 8'(i));
			bus(1'b1, 1'b0, `OFS_DATA_B, wd);
			crc = feed(crc, wd, 1'b1, ctrl);
			rd(`OFS_RESULT, outx(crc, ctrl[5:4]));
			rd(`OFS_CTRL, ctrl);
		end
		// full-rate writes left nothing queued and nothing dropped
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		rd(`OFS_STATUS, 32'h0000_0100);
		// frozen engine: queue fills, refuses the ninth word, flags the drop
		bus(1'b1, 1'b0, `OFS_CTRL, 32'h0000_0080);
		for (int k = 0; k < 9; k++) bus(1'b1, 1'b0, `OFS_DATA_W, 32'(k));
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		chk({31'h0, dataReady}, 32'h0);
		rd(`OFS_STATUS, 32'h0000_0608);
		bus(1'b1, 1'b0, `OFS_STATUS, 32'h0000_0400);
		rd(`OFS_STATUS, 32'h0000_0208);
		rd(`OFS_RESULT, `CRC_RESET);
		// result is read-only, unmapped reads give zero, config write flushes and seeds
		bus(1'b1, 1'b0, `OFS_RESULT, 32'hDEAD_BEEF);
		rd(8'h20, 32'h0000_0000);
		bus(1'b1, 1'b0, `OFS_CTRL, 32'h0000_0040);
		rd(`OFS_STATUS, 32'h0000_0100);
		rd(`OFS_RESULT, `SEED32_ONES);
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		#1 chk(rdata, 32'h0000_0000);
		// firmware request starts the block writer, 16-bit mode seeded with ones
		bus(1'b1, 1'b0, `OFS_CTRL, 32'h0000_0141);
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		for (int t = 0; t < 8 && !fBusy; t++) @(posedge clk);
		for (int t = 0; t < 40 && fBusy; t++) @(posedge clk);
		crc = `SEED16_ONES;
		for (int k = 0; k < 5; k++) crc = fold(crc, 32'hC0DE_0000 + 32'(k), 32, 2'h1);
		rd(`OFS_RESULT, crc);
		chk(32'(reqCycles), 32'h0000_0001);
		finish_test();
	end
endmodule // tb
`default_nettype wire
